// [rtl/pmt_pkg.sv]
package pmt_pkg;

  localparam int          PMT_NUM_TIMERS  = 3;
  localparam int          PMT_IDX_W       = 2;

  // register offsets on the plain register port, per instance a group of 4
  localparam logic [3:0]  PMT_OFS_CONTROL = 4'h0;
  localparam logic [3:0]  PMT_OFS_COUNT   = 4'h1;
  localparam logic [3:0]  PMT_OFS_PERIOD  = 4'h2;
  localparam logic [3:0]  PMT_OFS_IRQ_FLG = 4'hC;
  localparam logic [3:0]  PMT_OFS_IRQ_EN  = 4'hD;

  // control field positions
  localparam int          PMT_CTL_PRE_LSB  = 0;
  localparam int          PMT_CTL_RUN_BIT  = 2;
  localparam int          PMT_CTL_POST_LSB = 3;

  // reset values
  localparam logic [7:0]  PMT_RST_CONTROL = 8'h00;
  localparam logic [7:0]  PMT_RST_COUNT   = 8'h00;
  localparam logic [7:0]  PMT_RST_PERIOD  = 8'hFF;
  localparam logic [6:0]  PMT_CTL_MASK    = 7'h7F;

  // instruction clock is one quarter of the oscillator clock
  localparam logic [1:0]  PMT_INSTR_DIV_LAST = 2'h3;

  // prescale terminal counts for 1, 4, 16, 64
  localparam logic [5:0]  PMT_PRE_LAST_1  = 6'h00;
  localparam logic [5:0]  PMT_PRE_LAST_4  = 6'h03;
  localparam logic [5:0]  PMT_PRE_LAST_16 = 6'h0F;
  localparam logic [5:0]  PMT_PRE_LAST_64 = 6'h3F;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic       timer_run;
    logic [1:0] prescale_select;
  } pmt_control_s;

  function automatic logic [5:0] pmt_pre_last(input logic [1:0] sel);
    logic [5:0] r;
    r = PMT_PRE_LAST_1;
    case (sel)
      2'h1:    r = PMT_PRE_LAST_4;
      2'h2:    r = PMT_PRE_LAST_16;
      2'h3:    r = PMT_PRE_LAST_64;
      default: r = PMT_PRE_LAST_1;
    endcase
    return r;
  endfunction

endpackage

// [rtl/pmt_timer_bank.sv]
`timescale 1ns/1ns
module pmt_timer_bank
  import pmt_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST_B,
  input  wire logic       SLEEP_IN,
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic      [2:0] PWM_TIMEBASE,
  output logic            SERIAL_SHIFT_CLK,
  output logic            IRQ
);

  logic                   sleep_meta;
  logic                   sleep_sync;
  logic [1:0]             instr_div;
  logic                   instr_tick;
  logic [2:0]             match_flag;
  logic [2:0]             match_irq_enable;
  logic [2:0]             flag_set;
  logic [7:0]             rd_mux;
  logic [7:0]             count_rd [PMT_NUM_TIMERS];
  logic [7:0]             period_rd [PMT_NUM_TIMERS];
  logic [6:0]             ctl_rd [PMT_NUM_TIMERS];

  // sleep comes from the core's power control, asynchronous here
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= SLEEP_IN;
      sleep_sync <= sleep_meta;
    end
  end

  // instruction clock enable, one MCLK in four
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end
  assign instr_tick = (instr_div == PMT_INSTR_DIV_LAST) && !sleep_sync;

  wire       wr_flag  = REG_WR && (REG_ADDR == PMT_OFS_IRQ_FLG);
  wire       wr_en    = REG_WR && (REG_ADDR == PMT_OFS_IRQ_EN);

  genvar g;
  generate
    for (g = 0; g < PMT_NUM_TIMERS; g++) begin : g_tmr
      pmt_control_s control;
      logic [7:0]   count_value;
      logic [7:0]   period_value;
      logic [5:0]   pre_cnt;
      logic [3:0]   post_cnt;
      logic         pre_tick;
      logic         match;

      wire [3:0] base     = 4'(g * 4);
      wire       wr_ctl   = REG_WR && (REG_ADDR == (base | PMT_OFS_CONTROL));
      wire       wr_cnt   = REG_WR && (REG_ADDR == (base | PMT_OFS_COUNT));
      wire       wr_per   = REG_WR && (REG_ADDR == (base | PMT_OFS_PERIOD));
      wire       clr_sc   = wr_ctl || wr_cnt;
      wire       run_tick = instr_tick && control.timer_run;

      assign pre_tick = run_tick && (pre_cnt == pmt_pre_last(control.prescale_select));
      assign match    = pre_tick && (count_value == period_value);

      always_ff @(posedge MCLK) begin
        if (!RST_B) begin
          control <= pmt_control_s'(PMT_RST_CONTROL[6:0]);
        end else if (wr_ctl) begin
          control <= pmt_control_s'(REG_WDATA[6:0] & PMT_CTL_MASK);
        end
      end

      always_ff @(posedge MCLK) begin
        if (!RST_B || clr_sc) begin
          pre_cnt <= 6'h00;
        end else if (run_tick) begin
          pre_cnt <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
        end
      end

      always_ff @(posedge MCLK) begin
        if (!RST_B) begin
          count_value <= PMT_RST_COUNT;
        end else if (wr_cnt) begin
          count_value <= REG_WDATA;
        end else if (match) begin
          count_value <= PMT_RST_COUNT;
        end else if (pre_tick) begin
          count_value <= count_value + 8'h01;
        end
      end

      always_ff @(posedge MCLK) begin
        if (!RST_B) begin
          period_value <= PMT_RST_PERIOD;
        end else if (wr_per) begin
          period_value <= REG_WDATA;
        end
      end

      // postscaler: flag on the match seen while post_cnt equals the select, then post_cnt wraps to 0
      always_ff @(posedge MCLK) begin
        if (!RST_B || clr_sc) begin
          post_cnt <= 4'h0;
        end else if (match) begin
          post_cnt <= (post_cnt == control.postscale_select) ? 4'h0 : post_cnt + 4'h1;
        end
      end

      assign flag_set[g]     = match && (post_cnt == control.postscale_select);
      assign PWM_TIMEBASE[g] = match;
      assign count_rd[g]     = count_value;
      assign period_rd[g]    = period_value;
      assign ctl_rd[g]       = control;
    end
  endgenerate

  assign SERIAL_SHIFT_CLK = PWM_TIMEBASE[0];

  // hardware set wins over a same-cycle write-one-to-clear
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      match_flag <= 3'h0;
    end else begin
      match_flag <= (match_flag & ~(wr_flag ? REG_WDATA[2:0] : 3'h0)) | flag_set;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      match_irq_enable <= 3'h0;
    end else if (wr_en) begin
      match_irq_enable <= REG_WDATA[2:0];
    end
  end

  assign IRQ = |(match_flag & match_irq_enable);

  wire [1:0] sel_idx = REG_ADDR[3:2];
  always_comb begin
    rd_mux = 8'h00;
    if (sel_idx != 2'h3) begin
      case (REG_ADDR[1:0])
        PMT_OFS_CONTROL[1:0]: rd_mux = {1'b0, ctl_rd[sel_idx]};
        PMT_OFS_COUNT[1:0]:   rd_mux = count_rd[sel_idx];
        PMT_OFS_PERIOD[1:0]:  rd_mux = period_rd[sel_idx];
        default:              rd_mux = 8'h00;
      endcase
    end else if (REG_ADDR == PMT_OFS_IRQ_FLG) begin
      rd_mux = {5'h00, match_flag};
    end else if (REG_ADDR == PMT_OFS_IRQ_EN) begin
      rd_mux = {5'h00, match_irq_enable};
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 8'h00;
    end
  end

endmodule

// [testbench/pmt_checker.sv]
`timescale 1ns/1ns
module pmt_checker
  import pmt_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_B,
  input wire logic       SLEEP_IN,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic [2:0] PWM_TIMEBASE,
  input wire logic       SERIAL_SHIFT_CLK,
  input wire logic       IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_stop;
    REG_WR && REG_ADDR == PMT_OFS_CONTROL && !REG_WDATA[PMT_CTL_RUN_BIT];
  endsequence
  sequence s_quiet;
    !REG_WR [*5];
  endsequence
  AST_SERCLK: assert property (SERIAL_SHIFT_CLK == PWM_TIMEBASE[0])
    else $error("shift clock differs from timer0 match");
  AST_PULSE_ONE: assert property ((PWM_TIMEBASE & $past(PWM_TIMEBASE)) == 3'h0)
    else $error("match pulse longer than one cycle");
  AST_SPACING: assert property (PWM_TIMEBASE[0] |=> !PWM_TIMEBASE[0] [*3])
    else $error("matches closer than one instruction tick");
  AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data outside the read answer cycle");
  AST_SLEEP: assert property (SLEEP_IN [*4] |-> PWM_TIMEBASE == 3'h0)
    else $error("match while sleeping");
  AST_IRQ_RISE: assert property ($rose(IRQ) |-> $past(PWM_TIMEBASE) != 3'h0 || $past(REG_WR))
    else $error("irq rose without match or write");
  AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(REG_WR))
    else $error("irq fell without a write");
  AST_STOP: assert property (s_stop ##1 s_quiet |-> !PWM_TIMEBASE[0])
    else $error("stopped timer produced a match");
endmodule
bind pmt_timer_bank pmt_checker u_chk (.MCLK(MCLK), .RST_B(RST_B), .SLEEP_IN(SLEEP_IN),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PWM_TIMEBASE(PWM_TIMEBASE), .SERIAL_SHIFT_CLK(SERIAL_SHIFT_CLK),
  .IRQ(IRQ));

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  import pmt_pkg::*;
  logic       mclk, rst_b, sleep_in, reg_wr, reg_rd, irq, ser_clk;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] pwm;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;
  pmt_timer_bank uut (.MCLK(mclk), .RST_B(rst_b), .SLEEP_IN(sleep_in), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .PWM_TIMEBASE(pwm), .SERIAL_SHIFT_CLK(ser_clk), .IRQ(irq));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded wait, sampled mid-cycle since the pulse is combinational
  task automatic wp(input int b);
    for (int i = 0; i < 2000; i++) begin
      @(negedge mclk);
      if (pwm[b] === 1'b1) return;
    end
    n_mismatch++;
    wrap_up();
  endtask
  task automatic meas(input int b, input int e);
    int t0;
    wp(b);
    t0 = cyc;
    wp(b);
    `CHK(cyc - t0, e)
  endtask
  task automatic t_regs();
    logic [3:0] a[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'hA, 4'hC};
    logic [7:0] e[7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v);
      `CHK(v, e[i])
    end
    wr(PMT_OFS_CONTROL, 8'hF8);
    rd(PMT_OFS_CONTROL, v);
    `CHK(v, 8'h78)
    // stop timer0 first so no tick lands between the count write and its read
    wr(PMT_OFS_CONTROL, 8'h00);
    wr(PMT_OFS_COUNT, 8'h5A);
    rd(PMT_OFS_COUNT, v);
    `CHK(v, 8'h5A)
    wr(PMT_OFS_COUNT, 8'h00);
    wr(PMT_OFS_CONTROL, 8'h00);
  endtask
  task automatic t_pre();
    logic [1:0] b;
    wr(PMT_OFS_PERIOD, 8'h02);
    wr(PMT_OFS_CONTROL, 8'h04);
    meas(0, 12);
    for (int p = 0; p < 4; p++) begin
      b = 2'(p % 3);
      wr({b, 2'b10}, 8'h00);
      wr({b, 2'b00}, 8'h04 | 8'(p));
      meas(int'(b), 4 << (2 * p));
      wr({b, 2'b00}, 8'h00);
    end
  endtask
  task automatic t_post();
    logic [3:0] n[3] = '{4'h0, 4'h2, 4'hF};
    logic [7:0] v;
    int         cnt;
    wr(PMT_OFS_IRQ_FLG, 8'h07);
    wr(PMT_OFS_IRQ_EN, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(PMT_OFS_CONTROL, {1'b0, n[k], 3'b000});
      wr(PMT_OFS_IRQ_FLG, 8'h01);
      wr(PMT_OFS_CONTROL, {1'b0, n[k], 3'b100});
      cnt = 0;
      for (int i = 0; i < 200 && irq !== 1'b1; i++) begin
        @(negedge mclk);
        if (pwm[0] === 1'b1) cnt++;
      end
      `CHK(cnt, int'(n[k]) + 1)
    end
    wr(PMT_OFS_IRQ_EN, 8'h00);
    @(negedge mclk);
    `CHK(irq, 1'b0)
    wr(PMT_OFS_CONTROL, 8'h00);
    rd(PMT_OFS_IRQ_FLG, v);
    `CHK(v, 8'h01)
    wr(PMT_OFS_IRQ_FLG, 8'h07);
    rd(PMT_OFS_IRQ_FLG, v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_hold();
    logic [7:0] v1, v2;
    wr(PMT_OFS_PERIOD, 8'hFF);
    wr(PMT_OFS_CONTROL, 8'h04);
    repeat (40) @(posedge mclk);
    sleep_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(PMT_OFS_COUNT, v1);
    repeat (40) @(posedge mclk);
    rd(PMT_OFS_COUNT, v2);
    `CHK(v2, v1)
    `CHK(v1 != 8'h00, 1'b1)
    sleep_in <= 1'b0;
    wr(PMT_OFS_CONTROL, 8'h00);
    rd(PMT_OFS_COUNT, v1);
    repeat (40) @(posedge mclk);
    rd(PMT_OFS_COUNT, v2);
    `CHK(v2, v1)
    rd(PMT_OFS_PERIOD, v1);
    `CHK(v1, 8'hFF)
  endtask
  initial begin
    {rst_b, sleep_in, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_pre();
    t_post();
    t_hold();
    wrap_up();
  end
endmodule
